// ---- rtl/ecf_cfg.svh ----
`ifndef ECF_CFG_SVH
`define ECF_CFG_SVH

// Register byte offsets
`define ECF_OFF_CTRL 12'h000
`define ECF_OFF_BUF 12'h004
`define ECF_OFF_STAT 12'h008
`define ECF_OFF_ISTAT 12'h00C
`define ECF_OFF_IMASK 12'h010

// Control field positions
`define ECF_CTRL_MODE_LSB 0
`define ECF_CTRL_MODE_MSB 2
`define ECF_CTRL_EPI_LSB 5
`define ECF_CTRL_EPI_MSB 6
`define ECF_CTRL_TSEL_BIT 7

// Status field positions
`define ECF_STAT_NE_BIT 0
`define ECF_STAT_OV_BIT 1
`define ECF_STAT_CNT_LSB 2
`define ECF_STAT_CNT_MSB 4

// Interrupt status and mask bits
`define ECF_IRQ_CAP_BIT 0
`define ECF_IRQ_OV_BIT 1

// Reset values
`define ECF_CTRL_RESET 8'h00
`define ECF_IMASK_RESET 2'h0

// Buffer geometry and prescaler counts
`define ECF_FIFO_DEPTH 4
`define ECF_DATA_WIDTH 16
`define ECF_PRESCALE_4 4'h3
`define ECF_PRESCALE_16 4'hF

`endif

// ---- rtl/ecf_pkg.sv ----
package ecf_pkg;

  // Capture mode field encodings
  typedef enum logic [2:0] {
    ECF_MODE_OFF = 3'h0,
    ECF_MODE_EVERY_EDGE = 3'h1,
    ECF_MODE_FALL = 3'h2,
    ECF_MODE_RISE = 3'h3,
    ECF_MODE_RISE_4 = 3'h4,
    ECF_MODE_RISE_16 = 3'h5,
    ECF_MODE_SPARE = 3'h6,
    ECF_MODE_IRQ_ONLY = 3'h7
  } ecf_mode_type;

  // Channel control register layout
  typedef struct packed {
    logic timebase_select;
    logic [1:0] events_per_interrupt;
    logic [1:0] spare;
    ecf_mode_type capture_mode_field;
  } ecf_ctrl_type;

  // Edges seen on the synchronised pin
  typedef struct packed {
    logic rise;
    logic fall;
  } ecf_edge_type;

endpackage

// ---- rtl/ecf_edge_detect.sv ----
`timescale 1ns/1ps
module ecf_edge_detect (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic pin, // Raw pin from outside
  output ecf_pkg::ecf_edge_type edges // One-cycle edge pulses
);
  import ecf_pkg::*;

  logic sync_a;
  logic sync_b;
  logic last;

  // Two-stage synchroniser; only sync_b reads sync_a
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
    end
  end

  // Previous level, compared against sync_b only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last <= 1'b0;
    end else begin
      last <= sync_b;
    end
  end

  // Registered pulses so consumers see clean strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edges <= '0;
    end else begin
      edges.rise <= sync_b & ~last;
      edges.fall <= ~sync_b & last;
    end
  end
endmodule

// ---- rtl/ecf_channel.sv ----
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "ecf_cfg.svh"
module ecf_channel #(
  parameter int DEPTH = `ECF_FIFO_DEPTH, // Buffer entries
  parameter int WIDTH = `ECF_DATA_WIDTH // Bits per entry
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped
  input wire logic capture_in, // Edge input pin
  input wire logic [WIDTH-1:0] first_timebase, // Timer A count
  input wire logic [WIDTH-1:0] second_timebase, // Timer B count
  output logic capture_buf_not_empty, // Buffer holds data
  output logic capture_overflow_flag, // Overflow seen
  output logic irq // Level interrupt
);
  import ecf_pkg::*;

  localparam int CW = $clog2(DEPTH + 1);

  ecf_ctrl_type capture_channel_control;
  ecf_edge_type edges;
  logic [WIDTH-1:0] fifo [DEPTH];
  logic [CW-1:0] count;
  logic [3:0] prescale;
  logic [1:0] epi_count;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic access;
  logic do_write;
  logic do_read;
  logic addr_ok;
  logic pop;
  logic event_hit;
  logic push;
  logic discard_ov;
  logic cap_irq;
  logic epi_wrap;
  logic [WIDTH-1:0] stamp;
  logic [CW-1:0] next_count;
  logic [1:0] next_irq_stat;
  logic [31:0] read_mux;
  ecf_mode_type mode;

  // Pin synchroniser and edge detector
  ecf_edge_detect u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin(capture_in),
    .edges(edges)
  );

  assign mode = capture_channel_control.capture_mode_field;

  // One wait state: pready rises in the second access cycle
  assign access = psel & penable & ~pready;
  assign do_write = access & pwrite;
  assign do_read = access & ~pwrite;

  // Address decode over the five mapped words
  always_comb begin
    unique case (paddr)
      `ECF_OFF_CTRL,
      `ECF_OFF_BUF,
      `ECF_OFF_STAT,
      `ECF_OFF_ISTAT,
      `ECF_OFF_IMASK: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Popping the buffer on a read of its word
  assign pop = do_read & (paddr == `ECF_OFF_BUF) & (count != '0);

  // Selected time base, default is the second one
  assign stamp = capture_channel_control.timebase_select
    ? first_timebase : second_timebase;

  // Qualifying capture event per mode
  always_comb begin
    unique case (mode)
      ECF_MODE_EVERY_EDGE: event_hit = edges.rise | edges.fall;
      ECF_MODE_FALL: event_hit = edges.fall;
      ECF_MODE_RISE: event_hit = edges.rise;
      ECF_MODE_RISE_4: event_hit = edges.rise & (prescale == `ECF_PRESCALE_4);
      ECF_MODE_RISE_16: event_hit = edges.rise & (prescale == `ECF_PRESCALE_16);
      ECF_MODE_IRQ_ONLY: event_hit = edges.rise;
      default: event_hit = 1'b0;
    endcase
  end

  // Overflow only outside every-edge mode; the offender is dropped
  assign discard_ov = event_hit & (count == CW'(DEPTH)) & ~pop
    & (mode != ECF_MODE_EVERY_EDGE);

  // Interrupt-only mode raises no capture; overflow blocks captures
  assign push = event_hit & (mode != ECF_MODE_IRQ_ONLY)
    & ~capture_overflow_flag
    & ((count != CW'(DEPTH)) | pop);

  // Events-per-interrupt wrap, bypassed in every-edge mode
  assign epi_wrap =
    epi_count == capture_channel_control.events_per_interrupt;
  assign cap_irq = (mode == ECF_MODE_EVERY_EDGE)
    ? event_hit
    : (event_hit & ~capture_overflow_flag & epi_wrap);

  // Buffer occupancy after this cycle
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + CW'(1);
    end else if (pop && !push) begin
      next_count = count - CW'(1);
    end
  end

  // Prescaler for every-4th and every-16th rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale <= 4'h0;
    end else if (do_write && paddr == `ECF_OFF_CTRL) begin
      prescale <= 4'h0;
    end else if (edges.rise) begin
      if ((mode == ECF_MODE_RISE_4 && prescale == `ECF_PRESCALE_4)
          || mode != ECF_MODE_RISE_4 && mode != ECF_MODE_RISE_16) begin
        prescale <= 4'h0;
      end else begin
        prescale <= prescale + 4'h1;
      end
    end
  end

  // Event counter toward the next interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      epi_count <= 2'h0;
    end else if (do_write && paddr == `ECF_OFF_CTRL) begin
      epi_count <= 2'h0;
    end else if (event_hit && mode != ECF_MODE_EVERY_EDGE
                 && !capture_overflow_flag) begin
      epi_count <= epi_wrap ? 2'h0 : epi_count + 2'h1;
    end
  end

  // Control register, software writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_channel_control <= ecf_ctrl_type'(`ECF_CTRL_RESET);
    end else if (do_write && paddr == `ECF_OFF_CTRL) begin
      capture_channel_control <= ecf_ctrl_type'(pwdata[7:0]);
    end
  end

  // Interrupt mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= `ECF_IMASK_RESET;
    end else if (do_write && paddr == `ECF_OFF_IMASK) begin
      irq_mask <= pwdata[1:0];
    end
  end

  // Buffer storage: shift on pop, write at first free slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        fifo[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (push && CW'(i) == (pop ? count - CW'(1) : count)) begin
          fifo[i] <= stamp;
        end else if (pop && i < DEPTH - 1) begin
          fifo[i] <= fifo[i+1];
        end
      end
    end
  end

  // Occupancy count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // Not-empty flag follows the occupancy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_buf_not_empty <= 1'b0;
    end else begin
      capture_buf_not_empty <= next_count != '0;
    end
  end

  // Overflow holds until the buffer has been read out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_overflow_flag <= 1'b0;
    end else if (discard_ov) begin
      capture_overflow_flag <= 1'b1;
    end else if (next_count == '0) begin
      capture_overflow_flag <= 1'b0;
    end
  end

  // Sticky event bits; a new event beats a read-clear
  always_comb begin
    next_irq_stat = irq_stat;
    if (do_read && paddr == `ECF_OFF_ISTAT) begin
      next_irq_stat = 2'h0;
    end
    if (cap_irq) begin
      next_irq_stat[`ECF_IRQ_CAP_BIT] = 1'b1;
    end
    if (discard_ov) begin
      next_irq_stat[`ECF_IRQ_OV_BIT] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 2'h0;
    end else begin
      irq_stat <= next_irq_stat;
    end
  end

  // Interrupt level from the settled status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_irq_stat & irq_mask);
    end
  end

  // Read data selection; empty buffer read yields stale head
  always_comb begin
    read_mux = 32'h0000_0000;
    unique case (paddr)
      `ECF_OFF_CTRL: read_mux[7:0] = capture_channel_control;
      `ECF_OFF_BUF: read_mux[WIDTH-1:0] = fifo[0];
      `ECF_OFF_STAT: begin
        read_mux[`ECF_STAT_NE_BIT] = capture_buf_not_empty;
        read_mux[`ECF_STAT_OV_BIT] = capture_overflow_flag;
        read_mux[`ECF_STAT_CNT_MSB:`ECF_STAT_CNT_LSB] = 3'(count);
      end
      `ECF_OFF_ISTAT: read_mux[1:0] = irq_stat;
      `ECF_OFF_IMASK: read_mux[1:0] = irq_mask;
      default: read_mux = 32'h0000_0000;
    endcase
  end

  // APB answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access;
      pslverr <= access & ~addr_ok;
      if (do_read) begin
        prdata <= read_mux;
      end
    end
  end
endmodule

// ---- testbench/ecf_channel_asserts.sv ----
`timescale 1ns/1ps
module ecf_channel_asserts #(
  parameter int WIDTH = 16 // Bits per entry
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic capture_in, // Edge pin
  input wire logic [WIDTH-1:0] first_timebase, // Timer A
  input wire logic [WIDTH-1:0] second_timebase, // Timer B
  input wire logic capture_buf_not_empty, // Buffer holds data
  input wire logic capture_overflow_flag, // Overflow seen
  input wire logic irq // Level interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  // First access cycle, where the action lands
  assign acc = psel && penable && !pready;
  a_ready_follows: assert property (acc |=> pready)
    else $error("no ready after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_unmapped_err: assert property (acc && paddr > 12'h010 |=> pslverr && pready)
    else $error("unmapped access not refused");
  a_rdata_hold: assert property (!pready |-> $stable(prdata))
    else $error("read data moved outside a read");
  a_nonempty_holds: assert property (
    capture_buf_not_empty && !(acc && !pwrite && paddr == 12'h004) |=> capture_buf_not_empty)
    else $error("not-empty dropped without a pop");
  a_ovf_when_full: assert property (
    $rose(capture_overflow_flag) |-> $past(capture_buf_not_empty) && capture_buf_not_empty)
    else $error("overflow with empty buffer");
  a_ovf_till_drain: assert property (
    $fell(capture_overflow_flag) |-> !capture_buf_not_empty)
    else $error("overflow cleared before drain");
endmodule

// ---- testbench/ecf_pin_src.sv ----
`timescale 1ns/1ps
module ecf_pin_src (
  input wire logic pclk, // System clock
  output logic pin // Edge line to the channel
);
  // Idles low; edges only on request, so no stray captures
  initial pin = 1'b0;
  // Edge launched just after a clock edge, like any other bench input
  task automatic flip();
    @(posedge pclk);
    pin <= ~pin;
  endtask
endmodule

// ---- testbench/tb_ecf_channel.sv ----
`timescale 1ns/1ps
module tb_ecf_channel;
  import ecf_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, capture_in, ne, ov, irq, err;
  logic [15:0] ta = '0, tb = '0;
  int errors = 0, checks_done = 0, ovf = 0, tsel = 0, m1 = 0;
  int q[$];
  always #20 pclk = ~pclk;
  ecf_pin_src SRC(.pclk(pclk), .pin(capture_in));
  ecf_channel DUT(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_in(capture_in), .first_timebase(ta), .second_timebase(tb),
    .capture_buf_not_empty(ne), .capture_overflow_flag(ov), .irq(irq));
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; an edge first so strobes never change twice in a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      $display("ERROR %0t no ready from slave", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // One pin edge with fresh timer values held steady through the capture
  task automatic ev(input int cap);
    ta <= 16'($urandom);
    tb <= 16'($urandom);
    SRC.flip();
    repeat (8) @(posedge pclk);
    if (cap) begin
      if (q.size() < 4 && !ovf) q.push_back(tsel ? int'(ta) : int'(tb));
      else if (!m1) ovf = 1;
    end
  endtask
  task automatic pop();
    apb(0, 12'h004, 0); // Only called with data queued
    chk(rd, 32'(q.pop_front()));
    if (q.size() == 0) ovf = 0;
  endtask
  task automatic stat();
    apb(0, 12'h008, 0);
    chk(rd, 32'(q.size() * 4 + ovf * 2 + (q.size() > 0)));
    chk({30'h0, ov, ne}, 32'(ovf * 2 + (q.size() > 0)));
  endtask
  // Watchdog well past the expected run length
  initial begin
    repeat (6000) @(posedge pclk);
    errors++;
    $display("ERROR %0t watchdog expired", $time);
    finish_test();
  end
  initial begin
    void'($urandom(32'h10ae_e8e1));
    repeat (8) @(posedge pclk);
    presetn <= 1;
    stat();
    apb(1, 12'h010, 0);
    apb(1, 12'h000, 32'h0000_0003);
    // Rising edges only, default time base, two past full
    for (int i = 0; i < 6; i++) begin
      ev(1);
      ev(0);
    end
    chk({31'h0, irq}, 0);
    apb(1, 12'h010, 32'h0000_0003);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 1);
    apb(0, 12'h00c, 0);
    chk(rd, 32'h0000_0003);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 0);
    stat();
    repeat (2) pop();
    ev(1);
    ev(0);
    repeat (2) pop();
    stat();
    // Every edge, first time base, four events per interrupt set
    tsel = 1;
    m1 = 1;
    apb(1, 12'h000, 32'h0000_00e1);
    for (int i = 0; i < 6; i++) ev(1);
    stat();
    apb(0, 12'h00c, 0);
    chk(rd, 32'h0000_0001);
    repeat (4) pop();
    // Every fourth rise, second time base, interrupt every second capture
    tsel = 0;
    m1 = 0;
    apb(1, 12'h000, 32'h0000_0024);
    for (int i = 0; i < 8; i++) begin
      ev(i % 4 == 3);
      ev(0);
      if (i == 3) begin
        apb(0, 12'h00c, 0);
        chk(rd, 32'h0000_0000);
      end
    end
    chk({31'h0, irq}, 1);
    apb(0, 12'h00c, 0);
    chk(rd, 32'h0000_0001);
    stat();
    repeat (2) pop();
    // Interrupt-only rise leaves the buffer empty
    apb(1, 12'h000, 32'h0000_0007);
    ev(0);
    stat();
    apb(0, 12'h00c, 0);
    chk(rd, 32'h0000_0001);
    // Falling edges only: the fall is kept, the rise ignored
    apb(1, 12'h000, 32'h0000_0002);
    ev(1);
    ev(0);
    pop();
    stat();
    apb(0, 12'h020, 0);
    chk({31'h0, err}, 1);
    finish_test();
  end
endmodule
bind ecf_channel ecf_channel_asserts #(.WIDTH(WIDTH)) u_chk(.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .capture_in, .first_timebase,
  .second_timebase, .capture_buf_not_empty, .capture_overflow_flag, .irq);
